// ---- inc/ers_map.svh ----
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH
// ============================================================
// Error codes, two's complement 16 bit
`define ERS_CODE_NONE     16'h0000
`define ERS_CODE_CMD      16'hFF9C
`define ERS_CODE_MISSING  16'hFF93
`define ERS_CODE_NUMERIC  16'hFF88
`define ERS_CODE_PROTECT  16'hFF35
`define ERS_CODE_CONFLICT 16'hFF23
`define ERS_CODE_RANGE    16'hFF22
`define ERS_CODE_TOOMUCH  16'hFF21
`define ERS_CODE_LISTLEN  16'hFF1E
`define ERS_CODE_HWERR    16'hFF10
`define ERS_CODE_HWMISS   16'hFF0F
`define ERS_CODE_VERR     16'hFED3
`define ERS_CODE_IERR     16'hFED2
`define ERS_CODE_MEMERR   16'hFEC9
`define ERS_CODE_OVERFLOW 16'hFEA2
`define ERS_CODE_QUERY    16'hFE70
`define ERS_CODE_UNTERM   16'hFE5C
// ============================================================
// Event status bit positions
`define ERS_BIT_QUERY     2
`define ERS_BIT_DEVICE    3
`define ERS_BIT_EXEC      4
`define ERS_BIT_CMD       5
// ============================================================
// Register offsets
`define ERS_REG_ESR       4'h0
`define ERS_REG_ERRQ      4'h1
`define ERS_REG_OPTIONS   4'h2
`define ERS_REG_OUTPUT    4'h3
`define ERS_REG_COUNT     4'h4
// ============================================================
// Option field positions and reset values
`define ERS_OPT_DC        0
`define ERS_OPT_LF        1
`define ERS_OPT_RO        2
`define ERS_OPT_RESET     3'h0
`define ERS_OPT_ALL       3'h7
`define ERS_OUT_RESET     3'b001
`define ERS_NEWLINE       8'h0A
`endif

// ---- inc/ers_pkg.sv ----
package ers_pkg;
    // Raised failure, one bit per cause
    typedef struct packed {
        logic notUnderstood;
        logic missingParam;
        logic notNumeric;
        logic protectedCmd;
        logic calNotEnabled;
        logic listDown;
        logic outOfRange;
        logic listFull;
        logic listLength;
        logic hwNoResponse;
        logic discoveryAccess;
        logic voltWindow;
        logic currWindow;
        logic memoryFail;
        logic bufferLost;
        logic unterminated;
    } ers_fault_t;

    // Output stage state
    typedef struct packed {
        logic outputOn;
        logic currentMode;
        logic setZero;
    } ers_out_t;

    typedef struct packed {
        logic clearActsAsReset;
        logic newlineOnEmptyRead;
        logic outputOnAfterReset;
    } ers_opts_t;

    typedef enum logic [1:0] {
        ERS_GRP_NONE     = 2'b00,
        ERS_GRP_STANDARD = 2'b01,
        ERS_GRP_LEGACY   = 2'b10
    } ers_grp_t;
endpackage : ers_pkg

// ---- logic/ers_core.sv ----
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "ers_map.svh"
// How it works
// RL1: Unparsed command queues -100, sets bit 5
// RL2: Missing parameter queues -109, command error
// RL3: Non-numeric argument queues -120, command error
// RL4: Protected command locked queues -203, bit 4
// RL5: Calibration locked or list down: -221
// RL6: Out of range value queues -222
// RL7: List full drops entries, queues -223
// RL8: Dwell length mismatch queues -226
// RL9: Hardware silent queues -240, execution error
// RL10: Discovery access queues -241, no bits
// RL11: Window fault in modes 1-3: off, -301/-302
// RL12: Save, recall, store failure queues -311
// RL13: Full queue records -350, device error
// RL14: Output buffer overflow queues -400, bit 2
// RL15: Unread query response queues -420
// RL16: Status-only clear keeps output settings
// RL17: Reset-like clear resets output fully
// RL18: Empty read returns newline if enabled
// RL19: Option clear: reset leaves output off, zero
// RL20: Option set: reset turns output on
// RL21: Group setting sets all three options
// RL22: Factory init: newline on, others off
// RL23: Queue FIFO, keeps oldest, overflow last
// RL24: Error query pops oldest, else 0
// RL25: Settings query reports three option flags
module ers_core
    import ers_pkg::*;
#(
    parameter int QDEPTH = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire ers_fault_t  fault,
    input  wire logic        protectedIsPassword,
    input  wire logic        passwordEnabled,
    input  wire logic [1:0]  errorCheckMode,
    input  wire logic        resetCmd,
    input  wire logic        deviceClear,
    input  wire logic        factoryDefaultInit,
    input  wire logic        optionSettingCommand,
    input  wire ers_grp_t    optionGroup,
    input  wire ers_opts_t   optionWrite,
    input  wire logic        outputOnCmd,
    input  wire logic        outputOffCmd,
    input  wire logic        bufferEmptyRead,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic [15:0]      rdData,
    output logic             newlineValid,
    output logic [7:0]       newlineChar,
    output ers_out_t         outState,
    output logic [7:0]       eventStatus
);
    // ============================================================
    // Error classification, one code per cycle in priority order
    localparam int QW = $clog2(QDEPTH);
    logic [15:0] code;
    logic        codeValid;
    logic [7:0]  esrSet;
    logic        windowActive;
    logic        windowOff;
    assign windowActive = (errorCheckMode != 2'h0);
    assign windowOff    = windowActive && (fault.voltWindow || fault.currWindow); // [RL11]

    always_comb begin
        code      = `ERS_CODE_NONE;
        codeValid = 1'b1;
        esrSet    = 8'h00;
        if (fault.notUnderstood) begin
            code = `ERS_CODE_CMD; // [RL1]
            esrSet[`ERS_BIT_CMD] = 1'b1;
        end else if (fault.missingParam) begin
            code = `ERS_CODE_MISSING; // [RL2]
            esrSet[`ERS_BIT_CMD] = 1'b1;
        end else if (fault.notNumeric) begin
            code = `ERS_CODE_NUMERIC; // [RL3]
            esrSet[`ERS_BIT_CMD] = 1'b1;
        end else if (fault.protectedCmd && !passwordEnabled) begin
            code = `ERS_CODE_PROTECT; // [RL4]
            esrSet[`ERS_BIT_EXEC] = 1'b1;
        end else if (fault.calNotEnabled || fault.listDown) begin
            code = `ERS_CODE_CONFLICT; // [RL5]
            esrSet[`ERS_BIT_EXEC] = 1'b1;
        end else if (fault.outOfRange) begin
            code = `ERS_CODE_RANGE; // [RL6]
            esrSet[`ERS_BIT_EXEC] = 1'b1;
        end else if (fault.listFull) begin
            code = `ERS_CODE_TOOMUCH; // [RL7]
            esrSet[`ERS_BIT_EXEC] = 1'b1;
        end else if (fault.listLength) begin
            code = `ERS_CODE_LISTLEN; // [RL8]
            esrSet[`ERS_BIT_EXEC] = 1'b1;
        end else if (fault.hwNoResponse) begin
            code = `ERS_CODE_HWERR; // [RL9]
            esrSet[`ERS_BIT_EXEC] = 1'b1;
        end else if (fault.discoveryAccess) begin
            code = `ERS_CODE_HWMISS; // [RL10]
        end else if (windowActive && fault.voltWindow) begin
            code = `ERS_CODE_VERR; // [RL11]
            esrSet[`ERS_BIT_DEVICE] = 1'b1;
        end else if (windowActive && fault.currWindow) begin
            code = `ERS_CODE_IERR; // [RL11]
            esrSet[`ERS_BIT_DEVICE] = 1'b1;
        end else if (fault.memoryFail) begin
            code = `ERS_CODE_MEMERR; // [RL12]
            esrSet[`ERS_BIT_DEVICE] = 1'b1;
        end else if (fault.bufferLost) begin
            code = `ERS_CODE_QUERY; // [RL14]
            esrSet[`ERS_BIT_QUERY] = 1'b1;
        end else if (fault.unterminated) begin
            code = `ERS_CODE_UNTERM; // [RL15]
            esrSet[`ERS_BIT_QUERY] = 1'b1;
        end else begin
            codeValid = 1'b0;
        end
    end

    // ============================================================
    // Error queue; last slot is kept for the overflow marker
    logic [15:0] queue [QDEPTH];
    logic [QW-1:0] rdPtr;
    logic [QW-1:0] wrPtr;
    logic [QW:0]   count;
    logic          overflowed;
    logic          popReq;
    logic          pushReq;
    logic          pushOvf;
    logic [15:0]   pushCode;
    logic          clearStatus;
    logic [QW:0]   fillLevel;
    logic          ovfHeld;

    assign clearStatus = deviceClear;
    // A clear empties the queue first, so a code raised in the same cycle survives
    assign fillLevel = clearStatus ? '0 : count;
    assign ovfHeld   = overflowed && !clearStatus;
    assign popReq  = rdStrobe && (addr == `ERS_REG_ERRQ) && (fillLevel != '0);  // [RL24]
    // Room for a real code while one slot stays free for the marker
    assign pushReq = codeValid && !ovfHeld && (fillLevel < (QW+1)'(QDEPTH - 1)); // [RL23]
    assign pushOvf = codeValid && !ovfHeld && (fillLevel == (QW+1)'(QDEPTH - 1)); // [RL13]
    assign pushCode = pushOvf ? `ERS_CODE_OVERFLOW : code;

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (pushReq || pushOvf) begin
            queue[wrPtr] <= pushCode; // [RL23]
        end
    end

    // Pointers and fill level; device clear empties the queue too
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdPtr      <= '0;
            wrPtr      <= '0;
            count      <= '0;
            overflowed <= 1'b0;
        end else if (clearStatus) begin
            // Old entries dropped; the fresh code, if any, becomes the head
            rdPtr      <= wrPtr;
            wrPtr      <= wrPtr + QW'(pushReq);
            count      <= (QW+1)'(pushReq);
            overflowed <= 1'b0;
        end else begin
            if (pushReq || pushOvf) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (popReq) begin
                rdPtr <= rdPtr + 1'b1; // [RL24]
            end
            count <= count + (QW+1)'(pushReq || pushOvf) - (QW+1)'(popReq);
            // Marker stays until software pops an entry and makes room again
            if (pushOvf) begin
                overflowed <= 1'b1; // [RL13]
            end else if (popReq) begin
                overflowed <= 1'b0;
            end
        end
    end

    // ============================================================
    // Standard event status: set wins over a read-clear
    logic esrRead;
    logic [7:0] overflowBit;
    assign esrRead = rdStrobe && (addr == `ERS_REG_ESR);
    always_comb begin
        overflowBit = 8'h00;
        overflowBit[`ERS_BIT_DEVICE] = pushOvf; // [RL13]
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            eventStatus <= 8'h00;
        end else if (clearStatus || esrRead) begin
            eventStatus <= esrSet | overflowBit; // [RL16]
        end else begin
            eventStatus <= eventStatus | esrSet | overflowBit;
        end
    end

    // ============================================================
    // System options
    ers_opts_t opts;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            opts <= `ERS_OPT_RESET;
        end else if (factoryDefaultInit) begin
            opts.newlineOnEmptyRead <= 1'b1; // [RL22]
            opts.clearActsAsReset   <= 1'b0;
            opts.outputOnAfterReset <= 1'b0;
        end else if (optionSettingCommand) begin
            case (optionGroup)
                ERS_GRP_STANDARD: opts <= '0; // [RL21]
                ERS_GRP_LEGACY:   opts <= `ERS_OPT_ALL; // [RL21]
                default:          opts <= optionWrite;
            endcase
        end else if (wrStrobe && (addr == `ERS_REG_OPTIONS)) begin
            opts.clearActsAsReset   <= wrData[`ERS_OPT_DC];
            opts.newlineOnEmptyRead <= wrData[`ERS_OPT_LF];
            opts.outputOnAfterReset <= wrData[`ERS_OPT_RO];
        end
    end

    // ============================================================
    // Output stage state; power-up always leaves the output off
    logic fullReset;
    assign fullReset = resetCmd || (deviceClear && opts.clearActsAsReset); // [RL17]
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            outState <= `ERS_OUT_RESET; // [RL19]
        end else if (fullReset) begin
            outState.setZero     <= 1'b1; // [RL19]
            outState.currentMode <= 1'b0;
            outState.outputOn    <= opts.outputOnAfterReset; // [RL20]
        end else if (windowOff || outputOffCmd) begin
            outState.outputOn <= 1'b0; // [RL11]
        end else if (outputOnCmd) begin
            outState.outputOn <= 1'b1; // [RL20]
            outState.setZero  <= 1'b0;
        end
    end

    // ============================================================
    // Newline on empty-buffer read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            newlineValid <= 1'b0;
            newlineChar  <= 8'h00;
        end else begin
            newlineValid <= bufferEmptyRead && opts.newlineOnEmptyRead; // [RL18]
            newlineChar  <= (bufferEmptyRead && opts.newlineOnEmptyRead) ? `ERS_NEWLINE : 8'h00;
        end
    end

    // ============================================================
    // Read port, data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData <= 16'h0000;
        end else if (rdStrobe) begin
            case (addr)
                `ERS_REG_ESR:     rdData <= {8'h00, eventStatus};
                `ERS_REG_ERRQ:    rdData <= (count != '0) ? queue[rdPtr] : `ERS_CODE_NONE; // [RL24]
                `ERS_REG_OPTIONS: rdData <= {13'h0000, opts.outputOnAfterReset,
                                             opts.newlineOnEmptyRead, opts.clearActsAsReset}; // [RL25]
                `ERS_REG_OUTPUT:  rdData <= {13'h0000, outState};
                `ERS_REG_COUNT:   rdData <= 16'(count);
                default:          rdData <= 16'h0000;
            endcase
        end else begin
            rdData <= 16'h0000;
        end
    end

    // ============================================================
    // Checks
    sequence s_cmdFault;
        fault.notUnderstood;
    endsequence
    property p_cmdBit;
        @(posedge sys_clk) disable iff (sys_rst)
        s_cmdFault |=> eventStatus[`ERS_BIT_CMD];
    endproperty
    a_cmdBit: assert property (p_cmdBit) else $error("command error bit not set"); // [RL1]

    property p_protect;
        @(posedge sys_clk) disable iff (sys_rst)
        (fault.protectedCmd && !passwordEnabled && !fault.notUnderstood && !fault.missingParam
         && !fault.notNumeric) |-> (code == `ERS_CODE_PROTECT);
    endproperty
    a_protect: assert property (p_protect) else $error("protected code wrong"); // [RL4]

    property p_discovery;
        @(posedge sys_clk) disable iff (sys_rst)
        (codeValid && code == `ERS_CODE_HWMISS && !pushOvf && !clearStatus && !esrRead)
            |=> (eventStatus == $past(eventStatus));
    endproperty
    a_discovery: assert property (p_discovery) else $error("discovery set a status bit"); // [RL10]

    property p_windowOff;
        @(posedge sys_clk) disable iff (sys_rst)
        (windowOff && !fullReset) |=> !outState.outputOn;
    endproperty
    a_windowOff: assert property (p_windowOff) else $error("window fault left output on"); // [RL11]

    property p_countBound;
        @(posedge sys_clk) disable iff (sys_rst)
        count <= (QW+1)'(QDEPTH);
    endproperty
    a_countBound: assert property (p_countBound) else $error("queue over depth"); // [RL23]

    property p_emptyRead;
        @(posedge sys_clk) disable iff (sys_rst)
        (rdStrobe && addr == `ERS_REG_ERRQ && count == '0) |=> (rdData == `ERS_CODE_NONE);
    endproperty
    a_emptyRead: assert property (p_emptyRead) else $error("empty queue read not zero"); // [RL24]

    property p_legacy;
        @(posedge sys_clk) disable iff (sys_rst)
        (optionSettingCommand && !factoryDefaultInit && optionGroup == ERS_GRP_LEGACY) |=> (opts == `ERS_OPT_ALL);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy group not applied"); // [RL21]

    property p_factory;
        @(posedge sys_clk) disable iff (sys_rst)
        factoryDefaultInit |=> (opts.newlineOnEmptyRead && !opts.clearActsAsReset && !opts.outputOnAfterReset);
    endproperty
    a_factory: assert property (p_factory) else $error("factory options wrong"); // [RL22]

    property p_resetOn;
        @(posedge sys_clk) disable iff (sys_rst)
        (resetCmd && opts.outputOnAfterReset) |=> (outState.outputOn && outState.setZero);
    endproperty
    a_resetOn: assert property (p_resetOn) else $error("reset did not turn output on"); // [RL20]

    sequence s_statusClear;
        deviceClear && !fullReset && !windowOff && !outputOffCmd && !outputOnCmd;
    endsequence
    property p_clearKeeps;
        @(posedge sys_clk) disable iff (sys_rst)
        s_statusClear |=> $stable(outState);
    endproperty
    a_clearKeeps: assert property (p_clearKeeps) else $error("status clear moved output"); // [RL16]

    property p_clearReset;
        @(posedge sys_clk) disable iff (sys_rst)
        (deviceClear && opts.clearActsAsReset)
            |=> (outState.setZero && !outState.currentMode && outState.outputOn == $past(opts.outputOnAfterReset));
    endproperty
    a_clearReset: assert property (p_clearReset) else $error("clear did not reset output"); // [RL17]

    property p_newline;
        @(posedge sys_clk) disable iff (sys_rst)
        (bufferEmptyRead && opts.newlineOnEmptyRead) |=> (newlineValid && newlineChar == `ERS_NEWLINE);
    endproperty
    a_newline: assert property (p_newline) else $error("newline missing"); // [RL18]

    property p_overflow;
        @(posedge sys_clk) disable iff (sys_rst)
        (pushOvf && !popReq) |=> (overflowed && eventStatus[`ERS_BIT_DEVICE] && count == (QW+1)'(QDEPTH));
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow marker not kept"); // [RL13]

    property p_pop;
        @(posedge sys_clk) disable iff (sys_rst)
        (popReq && !pushReq && !pushOvf) |=> (count == $past(count) - 1'b1);
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not remove entry"); // [RL24]
endmodule : ers_core

// ---- tb/error_reporting_and_system_settings_tb.sv ----
`timescale 1ns/10ps
`include "ers_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nFail++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module error_reporting_and_system_settings_tb
    import ers_pkg::*;
;
    // ============================================================
    // Stimulus and observed signals
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    ers_fault_t  fault = '0;
    logic [1:0]  errorCheckMode = 2'h0;
    logic        passwordEnabled = 1'b0;
    logic [6:0]  ctl = 7'h00;
    ers_grp_t    optionGroup = ERS_GRP_NONE;
    ers_opts_t   optionWrite = '0;
    wire  [3:0]  addr;
    wire  [15:0] wrData;
    wire         wrStrobe;
    wire         rdStrobe;
    logic [15:0] rdData;
    logic        newlineValid;
    logic [7:0]  newlineChar;
    ers_out_t    outState;
    logic [7:0]  eventStatus;
    int          nFail = 0;
    int          checked = 0;
    int          seed = 17110;
    int          idx;
    logic [15:0] rv;
    logic [15:0] expQ [$];
    localparam logic [6:0] C_RST = 7'h01, C_CLR = 7'h02, C_FAC = 7'h04, C_OPT = 7'h08;
    localparam logic [6:0] C_ON = 7'h10, C_OFF = 7'h20, C_EMPTY = 7'h40;
    localparam logic [15:0] CODES [16] = '{`ERS_CODE_CMD, `ERS_CODE_MISSING, `ERS_CODE_NUMERIC, `ERS_CODE_PROTECT,
        `ERS_CODE_CONFLICT, `ERS_CODE_CONFLICT, `ERS_CODE_RANGE, `ERS_CODE_TOOMUCH, `ERS_CODE_LISTLEN,
        `ERS_CODE_HWERR, `ERS_CODE_HWMISS, `ERS_CODE_VERR, `ERS_CODE_IERR, `ERS_CODE_MEMERR,
        `ERS_CODE_QUERY, `ERS_CODE_UNTERM};

    always #25 sys_clk = ~sys_clk;

    ers_core DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .fault(fault), .protectedIsPassword(1'b0),
        .passwordEnabled(passwordEnabled), .errorCheckMode(errorCheckMode), .resetCmd(ctl[0]), .deviceClear(ctl[1]),
        .factoryDefaultInit(ctl[2]), .optionSettingCommand(ctl[3]), .optionGroup(optionGroup),
        .optionWrite(optionWrite), .outputOnCmd(ctl[4]), .outputOffCmd(ctl[5]), .bufferEmptyRead(ctl[6]),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .newlineValid(newlineValid), .newlineChar(newlineChar), .outState(outState), .eventStatus(eventStatus));

    ers_host_model host (.sys_clk(sys_clk), .rdData(rdData), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));

    // ============================================================
    // Expectations: cause index follows the fault struct order
    function automatic logic [15:0] exp_code(input int i);
        return CODES[i];
    endfunction : exp_code

    function automatic logic [7:0] exp_esr(input int i);
        if (i < 3) return 8'h20;
        if (i < 10) return 8'h10;
        if (i == 10) return 8'h00;
        if (i < 14) return 8'h08;
        return 8'h04;
    endfunction : exp_esr

    // ============================================================
    // Drivers
    task automatic pulse(input ers_fault_t f, input logic [6:0] c);
        @(posedge sys_clk);
        fault <= f;
        ctl <= c;
        @(posedge sys_clk);
        fault <= '0;
        ctl <= 7'h00;
        #1;
    endtask : pulse

    task automatic expect_rd(input logic [3:0] a, input logic [15:0] e);
        host.rd_reg(a, rv);
        `CHK(rv, e)
    endtask : expect_rd

    task automatic opt_cmd(input ers_grp_t g, input ers_opts_t w);
        @(posedge sys_clk);
        optionGroup <= g;
        optionWrite <= w;
        pulse('0, C_OPT);
    endtask : opt_cmd

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, nFail);
        if (nFail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        nFail++;
        report_and_stop();
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(outState, 3'b001)
        `CHK(eventStatus, 8'h00)
        expect_rd(4'h1, `ERS_CODE_NONE);
        expect_rd(4'h2, 16'h0000);
        expect_rd(4'h3, 16'h0001);
        expect_rd(4'hF, 16'h0000);
        $display("reset test done");
        // Every cause alone; window faults need a nonzero check mode and a live output
        @(posedge sys_clk);
        errorCheckMode <= 2'h1 + 2'($unsigned($random(seed)) % 3);
        for (int i = 0; i < 16; i++) begin
            if (i == 11 || i == 12) pulse('0, C_ON);
            if (i == 11 || i == 12) `CHK(outState.outputOn, 1'b1)
            pulse(ers_fault_t'(16'h8000 >> i), 7'h00);
            `CHK(eventStatus, exp_esr(i))
            if (i == 11 || i == 12) `CHK(outState.outputOn, 1'b0)
            expect_rd(4'h4, 16'h0001);
            expect_rd(4'h1, exp_code(i));
            expect_rd(4'h0, {8'h00, exp_esr(i)});
            expect_rd(4'h0, 16'h0000);
        end
        $display("cause test done");
        // Unlocked protected command and a window fault with checking off raise nothing
        pulse('0, C_ON);
        @(posedge sys_clk);
        passwordEnabled <= 1'b1;
        errorCheckMode  <= 2'h0;
        pulse(ers_fault_t'(16'h1010), 7'h00);
        `CHK(eventStatus, 8'h00)
        `CHK(outState.outputOn, 1'b1)
        expect_rd(4'h4, 16'h0000);
        @(posedge sys_clk);
        passwordEnabled <= 1'b0;
        errorCheckMode  <= 2'h1 + 2'($unsigned($random(seed)) % 3);
        $display("unlock test done");
        // Two causes at once: only the earlier one in the list is queued
        repeat (4) begin
            idx = $unsigned($random(seed)) % 15;
            pulse(ers_fault_t'((16'h8000 >> idx) | (16'h0001 << ($unsigned($random(seed)) % (15 - idx)))), 7'h00);
            expect_rd(4'h4, 16'h0001);
            expect_rd(4'h1, exp_code(idx));
            host.rd_reg(4'h0, rv);
        end
        $display("priority test done");
        // Back-to-back faults past the queue depth
        for (int i = 0; i < 18; i++) begin
            @(posedge sys_clk);
            idx = $unsigned($random(seed)) % 16;
            fault <= ers_fault_t'(16'h8000 >> idx);
            if (i < 15) expQ.push_back(exp_code(idx));
        end
        @(posedge sys_clk);
        fault <= '0;
        #1;
        `CHK(eventStatus[`ERS_BIT_DEVICE], 1'b1)
        expect_rd(4'h4, 16'h0010);
        foreach (expQ[k]) expect_rd(4'h1, expQ[k]);
        expect_rd(4'h1, `ERS_CODE_OVERFLOW);
        expect_rd(4'h1, `ERS_CODE_NONE);
        host.rd_reg(4'h0, rv);
        $display("overflow test done");
        // Option groups, direct write, factory init, register path
        opt_cmd(ERS_GRP_LEGACY, '0);
        expect_rd(4'h2, 16'h0007);
        opt_cmd(ERS_GRP_STANDARD, '1);
        expect_rd(4'h2, 16'h0000);
        opt_cmd(ERS_GRP_NONE, ers_opts_t'(3'($random(seed))));
        expect_rd(4'h2, {13'h0000, optionWrite.outputOnAfterReset, optionWrite.newlineOnEmptyRead,
            optionWrite.clearActsAsReset});
        pulse('0, C_FAC);
        expect_rd(4'h2, 16'h0002);
        rv = 16'($random(seed));
        host.wr_reg(4'h2, rv);
        host.wr_reg(4'hF, ~rv);
        expect_rd(4'h2, {13'h0000, rv[2:0]});
        $display("option test done");
        // Empty-buffer read with and without the newline option
        host.wr_reg(4'h2, 16'h0002);
        pulse('0, C_EMPTY);
        `CHK(newlineValid, 1'b1)
        `CHK(newlineChar, `ERS_NEWLINE)
        host.wr_reg(4'h2, 16'h0000);
        pulse('0, C_EMPTY);
        `CHK(newlineValid, 1'b0)
        `CHK(newlineChar, 8'h00)
        $display("newline test done");
        // Reset command under both output options
        host.wr_reg(4'h2, 16'h0004);
        pulse('0, C_RST);
        `CHK(outState, 3'b101)
        pulse('0, C_OFF);
        `CHK(outState.outputOn, 1'b0)
        host.wr_reg(4'h2, 16'h0000);
        pulse('0, C_ON);
        pulse('0, C_RST);
        `CHK(outState, 3'b001)
        $display("reset command test done");
        // Device clear: status only, then reset-like with both output options
        pulse('0, C_ON);
        pulse(ers_fault_t'(16'h8000), 7'h00);
        pulse('0, C_CLR);
        `CHK(eventStatus, 8'h00)
        `CHK(outState.outputOn, 1'b1)
        expect_rd(4'h4, 16'h0000);
        host.wr_reg(4'h2, 16'h0001);
        pulse('0, C_CLR);
        `CHK(outState, 3'b001)
        host.wr_reg(4'h2, 16'h0005);
        pulse('0, C_CLR);
        `CHK(outState, 3'b101)
        $display("device clear test done");
        // Power-up in mid-run leaves the output off even with the reset option set
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(outState, 3'b001)
        expect_rd(4'h2, 16'h0000);
        $display("power-up test done");
        report_and_stop();
    end
endmodule : error_reporting_and_system_settings_tb

// ---- tb/ers_host_model.sv ----
`timescale 1ns/10ps
// ============================================================
// Host controller model: drives the register port
module ers_host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] rdData,
    output logic [3:0]       addr,
    output logic [15:0]      wrData,
    output logic             wrStrobe,
    output logic             rdStrobe
);
    // Idle bus at time zero
    initial begin
        addr = 4'h0;
        wrData = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    // One-cycle write; address and data scrambled afterwards so stale values never look valid
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
        addr <= ~a;
        wrData <= ~d;
        #1;
    endtask : wr_reg

    // One-cycle read; data taken only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
        addr <= ~a;
        #1;
        d = rdData;
    endtask : rd_reg
endmodule : ers_host_model
